// ===== scp_defines.svh
// Offsets-free constants for the SPI clock phase and polarity block
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
`define SCP_DATA_BITS 8
`define SCP_EDGE_LAST 5'h0f
`define SCP_HALF_NS 24
`define SCP_LINK_PERIOD_NS 6
`define SCP_HALF_CYCLES ((`SCP_HALF_NS + `SCP_LINK_PERIOD_NS - 1) / `SCP_LINK_PERIOD_NS)
`define SCP_CFG_RESET 3'h0
`define SCP_BYTE_RESET 8'h00
`endif

// ===== scp_pkg.sv
// Types shared by the SPI clock phase and polarity block
package scp_pkg;
  typedef struct packed {
    logic clock_idle_polarity;
    logic capture_phase_select;
    logic launch_phase_select;
  } scp_cfg_s;
  typedef enum logic [1:0] {L_IDLE, L_RUN, L_TAIL} scp_lstate_e;
endpackage

// ===== scp_sync.sv
// Two flip-flop synchroniser, any width
`timescale 1ns/1ns
module scp_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk,
  // Asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule

// ===== scp_top.sv
// SPI master byte engine with selectable clock polarity and edge phases
`timescale 1ns/1ns
`include "scp_defines.svh"
// Notes on behaviour
// - Idle-high clock: capture rising when capture phase 1, falling when 0.
// - Idle-low clock: capture falling when capture phase 1, rising when 0.
// - Idle-high clock: launch falling when launch phase 1, rising when 0.
// - Idle-low clock: launch rising when launch phase 1, falling when 0.
// - Between transfers the serial clock rests at the idle polarity level.
module scp_top
  import scp_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  // Clocking settings
  input wire logic clock_idle_polarity,
  input wire logic capture_phase_select,
  input wire logic launch_phase_select,
  // Transfer request and answer
  input wire logic xfer_start,
  input wire logic [7:0] xfer_tx,
  output logic xfer_busy,
  output logic xfer_done,
  output logic [7:0] xfer_rx,
  // Serial link
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  localparam logic [1:0] HALF_LAST = 2'(`SCP_HALF_CYCLES - 1);

  // Core domain state
  scp_cfg_s cfg, next_cfg;
  logic [7:0] tx_word, next_tx_word;
  logic req_tgl, next_req_tgl;
  logic done_seen, next_done_seen;
  logic next_xfer_busy, next_xfer_done;
  logic [7:0] next_xfer_rx;
  logic done_sync;

  // Link domain state
  scp_lstate_e lstate, next_lstate;
  scp_cfg_s run_cfg, next_run_cfg;
  scp_cfg_s cfg_sync;
  logic [7:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic [1:0] half_cnt, next_half_cnt;
  logic [4:0] edge_cnt, next_edge_cnt;
  logic pend, next_pend;
  logic req_seen, next_req_seen;
  logic done_tgl, next_done_tgl;
  logic next_spi_sck, next_spi_cs_n, next_spi_mosi;
  logic req_sync, miso_sync, link_rst;
  logic new_sck, cap_edge, lau_edge;

  // Crossings: reset, request toggle, settings and data-in into the link clock
  scp_sync #(.WIDTH(1)) u_rst_sync (.clk(link_clk), .async_in(sys_rst), .sync_out(link_rst));
  scp_sync #(.WIDTH(1)) u_req_sync (.clk(link_clk), .async_in(req_tgl), .sync_out(req_sync));
  scp_sync #(.WIDTH(3)) u_cfg_sync (.clk(link_clk), .async_in(cfg), .sync_out(cfg_sync));
  scp_sync #(.WIDTH(1)) u_miso_sync (.clk(link_clk), .async_in(spi_miso), .sync_out(miso_sync));
  // Completion toggle back into the core clock
  scp_sync #(.WIDTH(1)) u_done_sync (.clk(core_clk), .async_in(done_tgl), .sync_out(done_sync));

  always_comb begin
    next_cfg = cfg;
    next_tx_word = tx_word;
    next_req_tgl = req_tgl;
    next_done_seen = done_seen;
    next_xfer_busy = xfer_busy;
    next_xfer_done = 1'b0;
    next_xfer_rx = xfer_rx;
    if (!xfer_busy) begin
      // Settings follow the inputs while idle
      next_cfg = '{clock_idle_polarity, capture_phase_select, launch_phase_select};
      if (xfer_start) begin
        // Frozen settings feed the link a full cycle before the toggle
        next_cfg = cfg;
        next_tx_word = xfer_tx;
        next_req_tgl = ~req_tgl;
        next_xfer_busy = 1'b1;
      end
    end else if (done_sync != done_seen) begin
      // Receive shifter is stable once the done toggle arrives
      next_done_seen = done_sync;
      // Fresh settings here too, so a back-to-back start never reuses the old ones
      next_cfg = '{clock_idle_polarity, capture_phase_select, launch_phase_select};
      next_xfer_rx = rx_sh;
      next_xfer_busy = 1'b0;
      next_xfer_done = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg <= `SCP_CFG_RESET;
      tx_word <= `SCP_BYTE_RESET;
      req_tgl <= 1'b0;
      done_seen <= 1'b0;
      xfer_busy <= 1'b0;
      xfer_done <= 1'b0;
      xfer_rx <= `SCP_BYTE_RESET;
    end else begin
      cfg <= next_cfg;
      tx_word <= next_tx_word;
      req_tgl <= next_req_tgl;
      done_seen <= next_done_seen;
      xfer_busy <= next_xfer_busy;
      xfer_done <= next_xfer_done;
      xfer_rx <= next_xfer_rx;
    end
  end

  // Edge roles: capture rising when polarity equals capture phase
  assign new_sck = ~spi_sck;
  assign cap_edge = (new_sck == ~(run_cfg.clock_idle_polarity ^
                    run_cfg.capture_phase_select));
  assign lau_edge = (new_sck == (run_cfg.clock_idle_polarity ^
                    run_cfg.launch_phase_select));

  always_comb begin
    next_lstate = lstate;
    next_run_cfg = run_cfg;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_half_cnt = half_cnt;
    next_edge_cnt = edge_cnt;
    next_pend = pend;
    next_req_seen = req_seen;
    next_done_tgl = done_tgl;
    next_spi_sck = spi_sck;
    next_spi_cs_n = spi_cs_n;
    next_spi_mosi = spi_mosi;
    case (lstate)
      L_IDLE: begin
        next_spi_sck = cfg_sync.clock_idle_polarity;
        next_spi_cs_n = 1'b1;
        if (req_sync != req_seen) begin
          next_req_seen = req_sync;
          next_run_cfg = cfg_sync;
          next_spi_sck = cfg_sync.clock_idle_polarity;
          next_tx_sh = tx_word;
          next_spi_mosi = tx_word[7];
          next_half_cnt = 2'h0;
          next_edge_cnt = 5'h00;
          next_pend = 1'b0;
          next_spi_cs_n = 1'b0;
          next_lstate = L_RUN;
        end
      end
      L_RUN: begin
        if (half_cnt == HALF_LAST) begin
          next_half_cnt = 2'h0;
          next_spi_sck = new_sck;
          if (cap_edge) begin
            next_rx_sh = {rx_sh[6:0], miso_sync};
          end
          // First bit is already out, so a launch waits until the far side sampled
          if (lau_edge && pend) begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_spi_mosi = tx_sh[6];
            next_pend = 1'b0;
          end else if (!lau_edge) begin
            next_pend = 1'b1;
          end
          next_edge_cnt = edge_cnt + 5'h01;
          if (edge_cnt == `SCP_EDGE_LAST) begin
            next_lstate = L_TAIL;
          end
        end else begin
          next_half_cnt = half_cnt + 2'h1;
        end
      end
      L_TAIL: begin
        // Half a clock of hold before the select is released
        if (half_cnt == HALF_LAST) begin
          next_half_cnt = 2'h0;
          next_spi_cs_n = 1'b1;
          next_done_tgl = ~done_tgl;
          next_lstate = L_IDLE;
        end else begin
          next_half_cnt = half_cnt + 2'h1;
        end
      end
      default: begin
        next_lstate = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lstate <= L_IDLE;
      run_cfg <= `SCP_CFG_RESET;
      tx_sh <= `SCP_BYTE_RESET;
      rx_sh <= `SCP_BYTE_RESET;
      half_cnt <= 2'h0;
      edge_cnt <= 5'h00;
      pend <= 1'b0;
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
      spi_sck <= 1'b0;
      spi_cs_n <= 1'b1;
      spi_mosi <= 1'b0;
    end else begin
      lstate <= next_lstate;
      run_cfg <= next_run_cfg;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      half_cnt <= next_half_cnt;
      edge_cnt <= next_edge_cnt;
      pend <= next_pend;
      req_seen <= next_req_seen;
      done_tgl <= next_done_tgl;
      spi_sck <= next_spi_sck;
      spi_cs_n <= next_spi_cs_n;
      spi_mosi <= next_spi_mosi;
    end
  end
endmodule

// ===== scp_slave.sv
// Behavioural serial slave facing the master's link
`timescale 1ns/1ns
module scp_slave
  import scp_pkg::*;
(
  // Serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Mode, reply and byte heard
  input wire scp_cfg_s cfg,
  input wire logic [7:0] reply,
  output logic [7:0] heard
);
  logic [7:0] sh = 8'h00;
  initial spi_miso = 1'b0;
  always @(negedge spi_cs_n) begin
    sh = reply;
    spi_miso = reply[7];
  end
  // No pull on a released line, so never leave the stale bit
  always @(posedge spi_cs_n) spi_miso = ~spi_miso;
  always @(spi_sck) begin
    if (!spi_cs_n && spi_sck != (cfg.clock_idle_polarity ^ cfg.launch_phase_select))
      heard = {heard[6:0], spi_mosi};
    if (!spi_cs_n && spi_sck == (cfg.clock_idle_polarity == cfg.capture_phase_select)) begin
      sh = {sh[6:0], ~sh[7]};
      spi_miso = sh[7];
    end
  end
endmodule

// ===== scp_top_monitor.sv
// Checker for serial clock idle level and edge phases
`timescale 1ns/1ns
module scp_monitor
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic link_clk,
  input wire logic sys_rst,
  // Settings and status
  input wire logic clock_idle_polarity,
  input wire logic capture_phase_select,
  input wire logic launch_phase_select,
  input wire logic xfer_busy,
  // Serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_mosi
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (sys_rst);
  scp_cfg_s cfg, next_cfg;
  logic live;
  assign live = clock_idle_polarity;
  // Copy taken while deselected, held across the frame
  always_comb begin
    next_cfg = spi_cs_n ? {live, capture_phase_select, launch_phase_select} : cfg;
  end
  always_ff @(posedge link_clk) begin
    cfg <= next_cfg;
  end
  sequence s_quiet;
    spi_cs_n && $past(spi_cs_n, 24) && !xfer_busy && !$past(xfer_busy, 24);
  endsequence
  property p_idle;
    s_quiet ##0 live == $past(live, 24) |-> spi_sck == live;
  endproperty
  a_idle: assert property (p_idle) else $error("sck off idle");
  property p_start;
    $fell(spi_cs_n) |-> spi_sck == cfg.clock_idle_polarity;
  endproperty
  a_start: assert property (p_start) else $error("sck off at start");
  property p_end;
    $rose(spi_cs_n) |-> spi_sck == cfg.clock_idle_polarity;
  endproperty
  a_end: assert property (p_end) else $error("sck off at end");
  property p_launch;
    $changed(spi_mosi) && !spi_cs_n && !$past(spi_cs_n) |->
      $changed(spi_sck) && spi_sck == (cfg.clock_idle_polarity ^ cfg.launch_phase_select);
  endproperty
  a_launch: assert property (p_launch) else $error("bad launch");
  property p_capture;
    $changed(spi_sck) && !spi_cs_n
      && spi_sck == (cfg.clock_idle_polarity == cfg.capture_phase_select)
      && spi_sck != (cfg.clock_idle_polarity ^ cfg.launch_phase_select) |-> $stable(spi_mosi);
  endproperty
  a_capture: assert property (p_capture) else $error("mosi moved");
  property p_gap;
    $changed(spi_sck) && !spi_cs_n |=> $stable(spi_sck) [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("sck gap");
endmodule
bind scp_top scp_monitor mon (.link_clk, .sys_rst, .clock_idle_polarity,
  .capture_phase_select, .launch_phase_select, .xfer_busy, .spi_sck, .spi_cs_n, .spi_mosi);

// ===== tb_spi_clock_phase_polarity_config.sv
// Self-checking bench for the clock phase and polarity block
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb_spi_clock_phase_polarity_config
  import scp_pkg::*;
();
  logic core_clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, xfer_start = 1'b0;
  logic [7:0] xfer_tx = 8'h00, reply = 8'h00, xfer_rx, heard;
  scp_cfg_s set = 3'h0, slave_cfg = 3'h0;
  logic xfer_busy, xfer_done, spi_sck, spi_cs_n, spi_mosi, spi_miso;
  int seed = 17652, miscompares = 0, check_count = 0, cycles = 0, n;
  scp_top dut (.core_clk, .sys_rst, .link_clk, .clock_idle_polarity(set.clock_idle_polarity),
    .capture_phase_select(set.capture_phase_select),
    .launch_phase_select(set.launch_phase_select), .xfer_start, .xfer_tx, .xfer_busy,
    .xfer_done, .xfer_rx, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso);
  scp_slave peer (.spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .cfg(slave_cfg), .reply, .heard);
  initial forever #50 core_clk = ~core_clk;
  // A 2 ns offset keeps the link clock rising edges off the core clock edges
  initial begin
    #2;
    forever #3 link_clk = ~link_clk;
  end
  function automatic scp_cfg_s mode_of(int i);
    return scp_cfg_s'(i[2:0]);
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i < 8) repeat (3) @(negedge core_clk);
      slave_cfg = mode_of(i);
      xfer_tx = 8'($random(seed));
      reply = 8'($random(seed));
      if (i == 3) {xfer_tx, reply} = 16'h00ff;
      xfer_start = 1'b1;
      @(negedge core_clk);
      xfer_start = 1'b0;
      `CHK(xfer_busy, 1'b1)
      set = mode_of(i + 1);
      n = 0;
      while (xfer_done !== 1'b1 && n < 20) begin
        @(negedge core_clk);
        n++;
      end
      `CHK(xfer_done, 1'b1)
      `CHK(xfer_busy, 1'b0)
      `CHK(xfer_rx, reply)
      `CHK(heard, xfer_tx)
      $display("transfer %0d done", i);
    end
    set = 3'h4;
    repeat (3) @(negedge core_clk);
    `CHK(spi_sck, 1'b1)
    `CHK(spi_cs_n, 1'b1)
    set = 3'h0;
    repeat (3) @(negedge core_clk);
    `CHK(spi_sck, 1'b0)
    $display("idle level test done");
    tally_and_finish();
  end
endmodule
